// *** logic/occ_map.svh ***
`ifndef OCC_MAP_SVH
`define OCC_MAP_SVH
// Register indices on the plain register port
`define OCC_ADDR_W 3
`define OCC_IDX_CTRL 3'h0
`define OCC_IDX_PRI 3'h1
`define OCC_IDX_SEC 3'h2
`define OCC_IDX_IRQ_STAT 3'h3
`define OCC_IDX_IRQ_MASK 3'h4
// Control register fields
`define OCC_MODE_LSB 0
`define OCC_TSEL_BIT 3
`define OCC_FLT_BIT 4
`define OCC_IDLE_BIT 13
`define OCC_CTRL_RST 16'h0000
// Interrupt status layout
`define OCC_IRQ_EDGE_BIT 0
`define OCC_IRQ_FLT_BIT 1
`define OCC_IRQ_W 2
`endif

// *** logic/occ_pkg.sv ***
package occ_pkg;
  typedef enum logic [2:0] {
    OCC_OFF = 3'h0,
    OCC_ONE_HIGH = 3'h1,
    OCC_ONE_LOW = 3'h2,
    OCC_TOGGLE = 3'h3,
    OCC_DELAYED = 3'h4,
    OCC_CONT = 3'h5,
    OCC_PWM = 3'h6,
    OCC_PWM_FLT = 3'h7
  } occ_mode_t;

  typedef struct packed {
    logic idle_halt_select;
    logic pwm_fault_flag;
    logic time_base_select;
    occ_mode_t channel_mode_field;
  } occ_ctrl_t;
endpackage

// *** logic/occ_channel.sv ***
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "occ_map.svh"
module occ_channel #(
  parameter int unsigned CHANNEL_NUM = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`OCC_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic [15:0] timer2_i,
  input wire logic [15:0] timer3_i,
  input wire logic [15:0] timer2_period_i,
  input wire logic [15:0] timer3_period_i,
  input wire logic cpu_idle_i,
  input wire logic fault_input_a,
  input wire logic fault_input_b,
  input wire logic gpio_out_i,
  output logic channel_output_pin,
  output logic pin_owned_o,
  output logic irq_o
);
  import occ_pkg::*;

  typedef struct packed {
    occ_ctrl_t ctrl;
    logic [15:0] pri;
    logic [15:0] sec;
    logic [15:0] duty;
    logic out;
    logic done;
    logic [`OCC_IRQ_W-1:0] stat;
    logic [`OCC_IRQ_W-1:0] mask;
    logic flt_s1;
    logic flt_s2;
    logic flt_s3;
    logic idle_s1;
    logic idle_s2;
    logic [15:0] rdata;
  } occ_state_t;

  occ_state_t s_q;
  occ_state_t s_d;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] ctrl_word(input occ_ctrl_t c);
    logic [15:0] w;
    w = 16'h0000;
    w[`OCC_IDLE_BIT] = c.idle_halt_select;
    w[`OCC_FLT_BIT] = c.pwm_fault_flag;
    w[`OCC_TSEL_BIT] = c.time_base_select;
    w[2:0] = c.channel_mode_field;
    return w;
  endfunction

  function automatic logic is_pwm(input occ_mode_t m);
    return (m == OCC_PWM) || (m == OCC_PWM_FLT);
  endfunction

  // ==========================================================
  // Combinational next state
  logic [15:0] tmr;
  logic [15:0] per;
  logic fault_pin;
  logic run;
  logic hit_pri;
  logic hit_sec;
  logic rollover;
  logic fault_fall;
  logic new_out;
  occ_mode_t mode;

  always_comb begin
    s_d = s_q;
    mode = s_q.ctrl.channel_mode_field;
    tmr = s_q.ctrl.time_base_select ? timer3_i : timer2_i;
    per = s_q.ctrl.time_base_select ? timer3_period_i : timer2_period_i;
    fault_pin = (CHANNEL_NUM <= 4) ? fault_input_a : fault_input_b;
    s_d.flt_s1 = fault_pin;
    s_d.flt_s2 = s_q.flt_s1;
    s_d.flt_s3 = s_q.flt_s2;
    s_d.idle_s1 = cpu_idle_i;
    s_d.idle_s2 = s_q.idle_s1;
    fault_fall = s_q.flt_s3 && !s_q.flt_s2;
    run = !(s_q.ctrl.idle_halt_select && s_q.idle_s2);
    hit_pri = (tmr == s_q.pri);
    hit_sec = (tmr == s_q.sec);
    rollover = (tmr == per);
    new_out = s_q.out;
    if (run) begin
      unique case (mode)
        OCC_OFF: new_out = s_q.out;
        OCC_ONE_HIGH: if (hit_pri) new_out = 1'b1;
        OCC_ONE_LOW: if (hit_pri) new_out = 1'b0;
        OCC_TOGGLE: if (hit_pri) new_out = !s_q.out;
        OCC_DELAYED: begin
          // Pulse runs once, then locks out
          if (hit_pri && !s_q.done) new_out = 1'b1;
          if (hit_sec && s_q.out) begin
            new_out = 1'b0;
            s_d.done = 1'b1;
          end
        end
        OCC_CONT: begin
          if (hit_pri) new_out = 1'b1;
          if (hit_sec) new_out = 1'b0;
        end
        OCC_PWM, OCC_PWM_FLT: begin
          if (rollover) begin
            s_d.duty = s_q.sec;
            new_out = (s_q.sec != 16'h0000);
          end else if (tmr == s_q.duty) begin
            new_out = 1'b0;
          end
          if (mode == OCC_PWM_FLT && (s_q.ctrl.pwm_fault_flag ||
              fault_fall)) begin
            new_out = 1'b0;
          end
        end
      endcase
    end
    s_d.out = new_out;
    // Edge interrupts per mode
    if (run) begin
      unique case (mode)
        OCC_ONE_HIGH: if (new_out && !s_q.out)
          s_d.stat[`OCC_IRQ_EDGE_BIT] = 1'b1;
        OCC_ONE_LOW, OCC_DELAYED, OCC_CONT: if (!new_out && s_q.out)
          s_d.stat[`OCC_IRQ_EDGE_BIT] = 1'b1;
        OCC_TOGGLE: if (new_out != s_q.out)
          s_d.stat[`OCC_IRQ_EDGE_BIT] = 1'b1;
        default: ;
      endcase
    end
    // Fault flag: only hardware sets it; it clears on leaving mode 111
    if (mode != OCC_PWM_FLT) begin
      s_d.ctrl.pwm_fault_flag = 1'b0;
    end else if (run && fault_fall) begin
      s_d.ctrl.pwm_fault_flag = 1'b1;
      s_d.stat[`OCC_IRQ_FLT_BIT] = 1'b1;
    end
    // ========================================================
    // Register port
    s_d.rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        `OCC_IDX_CTRL: s_d.rdata = ctrl_word(s_q.ctrl);
        `OCC_IDX_PRI: s_d.rdata = s_q.pri;
        `OCC_IDX_SEC: s_d.rdata = s_q.sec;
        `OCC_IDX_IRQ_STAT: begin
          s_d.rdata = {14'h0000, s_q.stat};
          // New events in this cycle survive the clear unless their bit was already set
          s_d.stat = s_d.stat & ~s_q.stat;
        end
        `OCC_IDX_IRQ_MASK: s_d.rdata = {14'h0000, s_q.mask};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        `OCC_IDX_CTRL: begin
          s_d.ctrl.idle_halt_select = wdata_i[`OCC_IDLE_BIT];
          s_d.ctrl.time_base_select = wdata_i[`OCC_TSEL_BIT];
          s_d.ctrl.channel_mode_field =
            occ_mode_t'(wdata_i[2:0]);
          s_d.done = 1'b0;
          // Initial pin level for the new mode
          unique case (occ_mode_t'(wdata_i[2:0]))
            OCC_ONE_HIGH, OCC_DELAYED, OCC_CONT: s_d.out = 1'b0;
            OCC_ONE_LOW: s_d.out = 1'b1;
            OCC_PWM, OCC_PWM_FLT: begin
              s_d.out = (s_q.pri != 16'h0000);
              s_d.duty = s_q.pri;
            end
            default: ;
          endcase
        end
        `OCC_IDX_PRI: s_d.pri = wdata_i;
        `OCC_IDX_SEC: s_d.sec = wdata_i;
        `OCC_IDX_IRQ_MASK: s_d.mask = wdata_i[`OCC_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign pin_owned_o = (s_q.ctrl.channel_mode_field != OCC_OFF);
  assign channel_output_pin = pin_owned_o ? s_q.out : gpio_out_i;
  assign irq_o = |(s_q.stat & s_q.mask);
endmodule

// *** tb/occ_props.sv ***
`timescale 1ns/100ps
// ==========
// Port checks
module occ_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic gpio_out_i,
  input wire logic channel_output_pin,
  input wire logic pin_owned_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0)
    else $error("read data outside read slot");
  a_ctrl_unused: assert property ($past(rd_i) && $past(addr_i) == 3'h0 |->
    rdata_o[15:14] == 2'h0 && rdata_o[12:5] == 8'h0)
    else $error("unused control bits not zero");
  a_unmapped_rd: assert property ($past(rd_i) && $past(addr_i) > 3'h4 |->
    rdata_o == 16'h0) else $error("unmapped read not zero");
  a_off_gpio: assert property (!pin_owned_o |->
    channel_output_pin == gpio_out_i) else $error("pin not from port");
  a_off_frees: assert property (wr_i && addr_i == 3'h0 &&
    wdata_i[2:0] == 3'h0 |=> !pin_owned_o) else $error("pin kept");
  a_on_owns: assert property (wr_i && addr_i == 3'h0 &&
    wdata_i[2:0] != 3'h0 |=> pin_owned_o) else $error("pin not taken");
  a_start_low: assert property (wr_i && addr_i == 3'h0 &&
    wdata_i[2:0] inside {3'h1, 3'h4, 3'h5} |=> !channel_output_pin)
    else $error("pin not low at start");
  a_start_high: assert property (wr_i && addr_i == 3'h0 &&
    wdata_i[2:0] == 3'h2 |=> channel_output_pin)
    else $error("pin not high at start");
  c_pwm_flt: cover property (wr_i && addr_i == 3'h0 && wdata_i[2:0] == 3'h7);
  c_pin_rise: cover property ($rose(channel_output_pin));
  c_stat_rd: cover property (rd_i && addr_i == 3'h3);
endmodule
bind occ_channel occ_props u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .gpio_out_i(gpio_out_i),
  .channel_output_pin(channel_output_pin), .pin_owned_o(pin_owned_o));

// *** tb/tb_occ_channel.sv ***
`timescale 1ns/100ps
module tb_occ_channel;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, idle = 0, fa = 1, fb = 1;
  logic gpio = 0, run = 0, pin, owned, irq;
  logic [2:0] addr = 3'h0;
  logic [15:0] wd = 16'h0, rdat, t2 = 16'h0, t3 = 16'h000a;
  logic [15:0] per2 = 16'hffff;
  int mismatches = 0, n_compared = 0;
  occ_channel #(.CHANNEL_NUM(1)) uut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .timer2_i(t2), .timer3_i(t3), .timer2_period_i(per2),
    .timer3_period_i(16'hffff), .cpu_idle_i(idle), .fault_input_a(fa),
    .fault_input_b(fb), .gpio_out_i(gpio), .channel_output_pin(pin),
    .pin_owned_o(owned), .irq_o(irq));
  always #25 clk = ~clk;
  // Stopped timer sits at zero so each run starts clean
  always @(posedge clk) t2 <= run ? (t2 == per2 ? 16'h0 : t2 + 16'h1) : 16'h0;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (e !== g) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [2:0] a, logic [15:0] d);
    @(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
    @(posedge clk) wr <= 0;
    #1;
  endtask
  task automatic rd_reg(logic [2:0] a, logic [15:0] e, string nm);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    #1 chk(nm, e, rdat);
  endtask
  task automatic run_timer(int n);
    @(posedge clk) run <= 1;
    repeat (n) @(posedge clk);
    run <= 0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    for (int a = 0; a < 6; a++) rd_reg(a[2:0], 16'h0, "reset reg");
    gpio <= 1;
    #60 chk("port pin", 16'h1, {15'h0, pin});
    wr_reg(3'h0, 16'hffff);
    rd_reg(3'h0, 16'h200f, "ctrl bits");
    wr_reg(3'h0, 16'h0000);
  endtask
  task automatic t_modes();
    logic [15:0] ctl[5] = '{16'h0009, 16'h0003, 16'h0002, 16'h0004, 16'h0005};
    logic st[5] = '{0, 1, 1, 0, 0};
    logic af[5] = '{1, 0, 0, 0, 0};
    wr_reg(3'h1, 16'h000a);
    wr_reg(3'h2, 16'h000e);
    wr_reg(3'h4, 16'h0003);
    for (int i = 0; i < 5; i++) begin
      wr_reg(3'h0, ctl[i]);
      chk("start pin", {15'h0, st[i]}, {15'h0, pin});
      run_timer(20);
      chk("end pin", {15'h0, af[i]}, {15'h0, pin});
      chk("irq up", 16'h1, {15'h0, irq});
      rd_reg(3'h3, 16'h0001, "edge stat");
      chk("irq down", 16'h0, {15'h0, irq});
    end
  endtask
  task automatic t_fault();
    wr_reg(3'h4, 16'h0001);
    wr_reg(3'h0, 16'h0007);
    chk("pwm start", 16'h1, {15'h0, pin});
    fb <= 0;
    repeat (8) @(posedge clk);
    rd_reg(3'h0, 16'h0007, "other fault");
    fa <= 0;
    repeat (8) @(posedge clk);
    #1 chk("masked irq", 16'h0, {15'h0, irq});
    chk("fault pin", 16'h0, {15'h0, pin});
    wr_reg(3'h0, 16'h0007);
    rd_reg(3'h0, 16'h0017, "fault flag");
    rd_reg(3'h3, 16'h0002, "fault stat");
    wr_reg(3'h0, 16'h0000);
    chk("released", 16'h0, {15'h0, owned});
  endtask
  task automatic t_pwm_idle();
    wr_reg(3'h1, 16'h0004);
    wr_reg(3'h2, 16'h0014);
    per2 <= 16'h0010;
    wr_reg(3'h0, 16'h0006);
    chk("pwm high", 16'h1, {15'h0, pin});
    run_timer(30);
    chk("duty reload", 16'h1, {15'h0, pin});
    rd_reg(3'h3, 16'h0000, "pwm no irq");
    wr_reg(3'h0, 16'h2001);
    idle <= 1;
    repeat (4) @(posedge clk);
    run_timer(10);
    chk("idle halt", 16'h0, {15'h0, pin});
    idle <= 0;
    repeat (4) @(posedge clk);
    run_timer(10);
    chk("idle resume", 16'h1, {15'h0, pin});
    rd_reg(3'h3, 16'h0001, "resume stat");
    wr_reg(3'h0, 16'h0000);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_modes();
    t_fault();
    t_pwm_idle();
    close_out();
  end
  initial begin
    #500000;
    mismatches++;
    close_out();
  end
endmodule
